// ===== pkg/gcac_consts.vh
`ifndef GCAC_CONSTS_VH
`define GCAC_CONSTS_VH
// byte addresses seen in a serial frame
`define GCAC_ADR_XOUT 7'h04
`define GCAC_ADR_YOUT 7'h06
`define GCAC_ADR_XPK 7'h0c
`define GCAC_ADR_YPK 7'h0e
`define GCAC_ADR_XNULL 7'h10
`define GCAC_ADR_YNULL 7'h12
`define GCAC_ADR_XSCL 7'h14
`define GCAC_ADR_YSCL 7'h16
`define GCAC_ADR_XYPK 7'h1a
`define GCAC_ADR_STAT 7'h3c
`define GCAC_ADR_CMDLO 7'h3e
`define GCAC_ADR_CMDHI 7'h3f
// command bit positions
`define GCAC_CB_ANULL 0
`define GCAC_CB_FRST 1
`define GCAC_CB_DACL 2
`define GCAC_CB_FLUPD 3
`define GCAC_CB_STCLR 4
`define GCAC_CB_PKCLR 5
`define GCAC_CB_CPCOPY 6
`define GCAC_CB_SWRST 7
`define GCAC_CB_CBCLR 8
`define GCAC_CB_CFCLR 9
`define GCAC_CB_CPTR 10
// status bit positions
`define GCAC_ST_FLERR 2
`define GCAC_ST_ANBUSY 6
`define GCAC_ST_FLBUSY 7
// reset and load values
`define GCAC_RST_SCALE 12'h800
`define GCAC_RST_NULL 12'h000
`define GCAC_CPTR_INIT 16'h0001
`define GCAC_PEAK_CLR 14'h0000
// timing
`define GCAC_CLK_KHZ 50000
`define GCAC_FLUPD_MS 50
`define GCAC_CPCOPY_MS 120
`define GCAC_AN_SAMPLES 7'd64
`endif

// ===== design/gcac_core.v
`timescale 1ns/100ps
`include "gcac_consts.vh"
module gcac_core #(
  parameter [22:0] FLUPD_CYC = `GCAC_FLUPD_MS * `GCAC_CLK_KHZ,
  parameter [22:0] CPCOPY_CYC = `GCAC_CPCOPY_MS * `GCAC_CLK_KHZ
) (
  input wire CLK_SYS,
  input wire SRST,
  input wire CE,
  input wire SCLK,
  input wire CS_N,
  input wire DIN,
  input wire [13:0] X_RAW,
  input wire [13:0] Y_RAW,
  input wire [13:0] XY_RSS,
  input wire SAMPLE_VALID,
  input wire FLASH_FAIL,
  output reg DOUT,
  output reg DOUT_OE,
  output reg [13:0] X_CAL_OUT,
  output reg [13:0] Y_CAL_OUT,
  output reg CAL_VALID,
  output reg [13:0] X_PEAK_OUT,
  output reg [13:0] Y_PEAK_OUT,
  output reg [13:0] XY_PEAK_OUT,
  output reg FLASH_BUSY,
  output reg SW_RESET_P,
  output reg DAC_LATCH_P,
  output reg CPTR_LOAD_P,
  output reg [15:0] CPTR_VALUE,
  output reg CBUF_CLR_P,
  output reg CFLASH_CLR_P,
  output reg CFLASH_COPY_P,
  output reg STATUS_CLR_P
);

////////////////////////////////////////////////////////////////
// arithmetic helpers

// signed 14-bit times unsigned 12-bit scale, plus null, saturated
function [13:0] gcac_cal;
  input [13:0] raw;
  input [11:0] scl;
  input [11:0] nul;
  reg signed [26:0] prod;
  reg signed [16:0] sum;
  begin
    prod = $signed(raw) * $signed({1'b0, scl});
    // 0x800 is unity, so drop eleven fraction bits
    sum = $signed({prod[26], prod[26:11]}) + $signed({{5{nul[11]}}, nul});
    if (sum[16:13] == 4'h0 || sum[16:13] == 4'hf)
      gcac_cal = sum[13:0];
    else if (sum[16])
      gcac_cal = 14'h2000; // clamp negative
    else
      gcac_cal = 14'h1fff; // clamp positive
  end
endfunction

// magnitude; -8192 becomes 8192, still fits unsigned 14 bits
function [13:0] gcac_abs;
  input [13:0] v;
  begin
    gcac_abs = v[13] ? (14'h0000 - v) : v;
  end
endfunction

// negated mean of 64 samples, saturated to the 12-bit null range
function [11:0] gcac_null;
  input [19:0] acc;
  reg [14:0] neg;
  begin
    neg = 15'h0000 - {acc[19], acc[19:6]};
    if (neg[14:11] == 4'h0 || neg[14:11] == 4'hf)
      gcac_null = neg[11:0];
    else if (neg[14])
      gcac_null = 12'h800;
    else
      gcac_null = 12'h7ff;
  end
endfunction

////////////////////////////////////////////////////////////////
// state

reg [2:0] s1_r; // first sync stage {din,cs_n,sclk}
reg [2:0] s2_r; // second stage
reg [2:0] s3_r; // third stage
reg [2:0] pf_r; // filtered pins
reg [2:0] pp_r; // filtered pins, one cycle old
reg [4:0] bit_cnt_r; // rising edges in frame
reg [15:0] rx_r; // incoming shift
reg [15:0] tx_r; // outgoing shift
reg [6:0] rd_adr_r; // address for next frame's read
reg [11:0] xnull_r; // x offset null
reg [11:0] ynull_r; // y offset null
reg [11:0] xscl_r; // x gain trim
reg [11:0] yscl_r; // y gain trim
reg [11:0] xnull_nv_r; // stored copies
reg [11:0] ynull_nv_r;
reg [11:0] xscl_nv_r;
reg [11:0] yscl_nv_r;
reg [22:0] fl_cnt_r; // flash busy countdown
reg fl_upd_r; // running op is register save
reg fl_fail_r; // supply fault seen during save
reg fl_err_r; // sticky flash error
reg an_busy_r; // autonull collecting
reg [6:0] an_cnt_r; // samples taken
reg [19:0] an_xacc_r; // x sum
reg [19:0] an_yacc_r; // y sum

////////////////////////////////////////////////////////////////
// decode

wire [2:0] pins = {DIN, CS_N, SCLK};
wire sclk_f = pf_r[0];
wire cs_f = pf_r[1];
wire din_f = pf_r[2];
wire sclk_rise = sclk_f & ~pp_r[0] & ~cs_f;
wire sclk_fall = ~sclk_f & pp_r[0] & ~cs_f;
wire cs_fall = ~cs_f & pp_r[1];
wire [15:0] fw = {rx_r[14:0], din_f};
wire frame_done = sclk_rise & (bit_cnt_r == 5'd15);
wire wr_stb = frame_done & fw[15];
wire [6:0] wr_adr = fw[14:8];
wire [7:0] wr_dat = fw[7:0];
wire fl_busy = (fl_cnt_r != 23'h000000);
// flash-related work needs an idle flash and a clear error
wire fl_ok = ~fl_busy & ~fl_err_r;
wire [13:0] x_c = gcac_cal(X_RAW, xscl_r, xnull_r);
wire [13:0] y_c = gcac_cal(Y_RAW, yscl_r, ynull_r);

reg [15:0] cmd; // command bits written this cycle
reg [15:0] rdat; // word for the read port
reg rd_stat; // this load reads the status register

// each byte of the command word acts on its own write
always @* begin
  cmd = 16'h0000;
  if (wr_stb && wr_adr == `GCAC_ADR_CMDLO)
    cmd = {8'h00, wr_dat};
  else if (wr_stb && wr_adr == `GCAC_ADR_CMDHI)
    cmd = {5'h00, wr_dat[2:0], 8'h00};
end

// read mux, unused upper bits read zero
always @* begin
  rdat = 16'h0000;
  rd_stat = 1'b0;
  case ({rd_adr_r[6:1], 1'b0})
    `GCAC_ADR_XOUT: rdat = {2'h0, X_CAL_OUT};
    `GCAC_ADR_YOUT: rdat = {2'h0, Y_CAL_OUT};
    `GCAC_ADR_XPK: rdat = {2'h0, X_PEAK_OUT};
    `GCAC_ADR_YPK: rdat = {2'h0, Y_PEAK_OUT};
    `GCAC_ADR_XYPK: rdat = {2'h0, XY_PEAK_OUT};
    `GCAC_ADR_XNULL: rdat = {4'h0, xnull_r};
    `GCAC_ADR_YNULL: rdat = {4'h0, ynull_r};
    `GCAC_ADR_XSCL: rdat = {4'h0, xscl_r};
    `GCAC_ADR_YSCL: rdat = {4'h0, yscl_r};
    `GCAC_ADR_STAT: begin
      rd_stat = 1'b1;
      rdat[`GCAC_ST_FLERR] = fl_err_r;
      rdat[`GCAC_ST_ANBUSY] = an_busy_r;
      rdat[`GCAC_ST_FLBUSY] = fl_busy;
    end
    default: rdat = 16'h0000; // unmapped and command read zero
  endcase
end

////////////////////////////////////////////////////////////////
// serial port

// three stages; a pin change counts once stages two and three agree
always @(posedge CLK_SYS) begin
  if (SRST) begin
    // idle pin levels, so no false edge follows reset
    s1_r <= 3'h3;
    s2_r <= 3'h3;
    s3_r <= 3'h3;
    pf_r <= 3'h3;
    pp_r <= 3'h3;
  end else if (CE) begin
    s1_r <= pins;
    s2_r <= s1_r;
    s3_r <= s2_r;
    pf_r <= (s2_r & ~(s2_r ^ s3_r)) | (pf_r & (s2_r ^ s3_r));
    pp_r <= pf_r;
  end
end

// frame: write flag, 7-bit address, 8 data bits; reads answer next frame
always @(posedge CLK_SYS) begin
  if (SRST) begin
    bit_cnt_r <= 5'h00;
    rx_r <= 16'h0000;
    tx_r <= 16'h0000;
    rd_adr_r <= 7'h00;
    DOUT <= 1'b0;
    DOUT_OE <= 1'b0;
  end else if (CE) begin
    DOUT_OE <= ~cs_f;
    if (cs_f) begin
      bit_cnt_r <= 5'h00; // deselect aborts a partial frame
    end else if (cs_fall) begin
      bit_cnt_r <= 5'h00;
      tx_r <= rdat;
    end else begin
      if (sclk_rise) begin
        rx_r <= fw;
        bit_cnt_r <= frame_done ? 5'h00 : bit_cnt_r + 5'h01;
      end
      if (sclk_fall) begin
        // shift out on falling, host samples on rising
        DOUT <= tx_r[15];
        tx_r <= {tx_r[14:0], 1'b0};
      end
    end
    if (frame_done && !fw[15])
      rd_adr_r <= wr_adr;
  end
end

////////////////////////////////////////////////////////////////
// calibration registers and autonull

// priority: reload, factory restore, autonull result, host write
always @(posedge CLK_SYS) begin
  if (SRST) begin
    xnull_r <= `GCAC_RST_NULL;
    ynull_r <= `GCAC_RST_NULL;
    xscl_r <= `GCAC_RST_SCALE;
    yscl_r <= `GCAC_RST_SCALE;
    an_busy_r <= 1'b0;
    an_cnt_r <= 7'h00;
    an_xacc_r <= 20'h00000;
    an_yacc_r <= 20'h00000;
  end else if (CE) begin
    if (cmd[`GCAC_CB_SWRST]) begin
      xnull_r <= xnull_nv_r;
      ynull_r <= ynull_nv_r;
      xscl_r <= xscl_nv_r;
      yscl_r <= yscl_nv_r;
      an_busy_r <= 1'b0;
    end else if (cmd[`GCAC_CB_FRST]) begin
      xnull_r <= `GCAC_RST_NULL;
      ynull_r <= `GCAC_RST_NULL;
      xscl_r <= `GCAC_RST_SCALE;
      yscl_r <= `GCAC_RST_SCALE;
      an_busy_r <= 1'b0;
    end else if (an_busy_r) begin
      if (an_cnt_r == `GCAC_AN_SAMPLES) begin
        // opposite of the mean, same lsb as output
        xnull_r <= gcac_null(an_xacc_r);
        ynull_r <= gcac_null(an_yacc_r);
        an_busy_r <= 1'b0;
      end else if (SAMPLE_VALID) begin
        // raw data so the current null does not skew the mean
        an_xacc_r <= an_xacc_r + {{6{X_RAW[13]}}, X_RAW};
        an_yacc_r <= an_yacc_r + {{6{Y_RAW[13]}}, Y_RAW};
        an_cnt_r <= an_cnt_r + 7'h01;
      end
    end else if (cmd[`GCAC_CB_ANULL]) begin
      an_busy_r <= 1'b1;
      an_cnt_r <= 7'h00;
      an_xacc_r <= 20'h00000;
      an_yacc_r <= 20'h00000;
    end else if (wr_stb) begin
      // byte writes; bits 15:12 are dropped
      case (wr_adr)
        `GCAC_ADR_XNULL: xnull_r[7:0] <= wr_dat;
        `GCAC_ADR_XNULL + 7'h01: xnull_r[11:8] <= wr_dat[3:0];
        `GCAC_ADR_YNULL: ynull_r[7:0] <= wr_dat;
        `GCAC_ADR_YNULL + 7'h01: ynull_r[11:8] <= wr_dat[3:0];
        `GCAC_ADR_XSCL: xscl_r[7:0] <= wr_dat;
        `GCAC_ADR_XSCL + 7'h01: xscl_r[11:8] <= wr_dat[3:0];
        `GCAC_ADR_YSCL: yscl_r[7:0] <= wr_dat;
        `GCAC_ADR_YSCL + 7'h01: yscl_r[11:8] <= wr_dat[3:0];
        default: ;
      endcase
    end
  end
end

////////////////////////////////////////////////////////////////
// flash sequencing and status

// one timer serves both long operations; they never overlap
always @(posedge CLK_SYS) begin
  if (SRST) begin
    xnull_nv_r <= `GCAC_RST_NULL;
    ynull_nv_r <= `GCAC_RST_NULL;
    xscl_nv_r <= `GCAC_RST_SCALE;
    yscl_nv_r <= `GCAC_RST_SCALE;
    fl_cnt_r <= 23'h000000;
    fl_upd_r <= 1'b0;
    fl_fail_r <= 1'b0;
    fl_err_r <= 1'b0;
  end else if (CE) begin
    if (fl_busy) begin
      fl_cnt_r <= fl_cnt_r - 23'h000001;
      fl_fail_r <= fl_fail_r | FLASH_FAIL;
    end
    if (fl_ok && cmd[`GCAC_CB_FLUPD]) begin
      fl_cnt_r <= FLUPD_CYC;
      fl_upd_r <= 1'b1;
      fl_fail_r <= FLASH_FAIL;
    end else if (fl_ok && cmd[`GCAC_CB_CPCOPY]) begin
      fl_cnt_r <= CPCOPY_CYC;
      fl_upd_r <= 1'b0;
      fl_fail_r <= 1'b0;
    end
    // commit at the end; a supply fault keeps the old copy
    if (fl_upd_r && fl_cnt_r == 23'h000001) begin
      if (fl_fail_r || FLASH_FAIL) begin
        fl_err_r <= 1'b1;
      end else begin
        xnull_nv_r <= xnull_r;
        ynull_nv_r <= ynull_r;
        xscl_nv_r <= xscl_r;
        yscl_nv_r <= yscl_r;
      end
    end else if (cmd[`GCAC_CB_STCLR] || cmd[`GCAC_CB_SWRST]) begin
      fl_err_r <= 1'b0;
    end else if (cs_fall && rd_stat) begin
      fl_err_r <= 1'b0;
    end
  end
end

////////////////////////////////////////////////////////////////
// command pulses

// one-cycle strobes to the capture, dac and processor logic
always @(posedge CLK_SYS) begin
  if (SRST) begin
    SW_RESET_P <= 1'b0;
    DAC_LATCH_P <= 1'b0;
    CPTR_LOAD_P <= 1'b0;
    CPTR_VALUE <= `GCAC_CPTR_INIT;
    CBUF_CLR_P <= 1'b0;
    CFLASH_CLR_P <= 1'b0;
    CFLASH_COPY_P <= 1'b0;
    STATUS_CLR_P <= 1'b0;
    FLASH_BUSY <= 1'b0;
  end else if (CE) begin
    SW_RESET_P <= cmd[`GCAC_CB_SWRST];
    DAC_LATCH_P <= cmd[`GCAC_CB_DACL];
    CPTR_LOAD_P <= cmd[`GCAC_CB_CPTR];
    CPTR_VALUE <= `GCAC_CPTR_INIT;
    CBUF_CLR_P <= cmd[`GCAC_CB_CBCLR];
    // erase is flash work too, so it is dropped unless the flash is idle and error-free
    CFLASH_CLR_P <= cmd[`GCAC_CB_CFCLR] & fl_ok;
    CFLASH_COPY_P <= cmd[`GCAC_CB_CPCOPY] & fl_ok
      & ~cmd[`GCAC_CB_FLUPD];
    STATUS_CLR_P <= cmd[`GCAC_CB_STCLR];
    FLASH_BUSY <= fl_busy;
  end
end

////////////////////////////////////////////////////////////////
// calibrated outputs and peaks

// a sample in a peak-clear cycle is compared against zero, so it is kept; on software reset it meets the old peak
always @(posedge CLK_SYS) begin
  if (SRST) begin
    X_CAL_OUT <= 14'h0000;
    Y_CAL_OUT <= 14'h0000;
    CAL_VALID <= 1'b0;
    X_PEAK_OUT <= `GCAC_PEAK_CLR;
    Y_PEAK_OUT <= `GCAC_PEAK_CLR;
    XY_PEAK_OUT <= `GCAC_PEAK_CLR;
  end else if (CE) begin
    CAL_VALID <= SAMPLE_VALID;
    if (cmd[`GCAC_CB_PKCLR] || cmd[`GCAC_CB_SWRST]) begin
      X_PEAK_OUT <= `GCAC_PEAK_CLR;
      Y_PEAK_OUT <= `GCAC_PEAK_CLR;
      XY_PEAK_OUT <= `GCAC_PEAK_CLR;
    end
    if (SAMPLE_VALID) begin
      X_CAL_OUT <= x_c;
      Y_CAL_OUT <= y_c;
      if (gcac_abs(x_c) > gcac_abs(cmd[`GCAC_CB_PKCLR] ? 14'h0000 : X_PEAK_OUT))
        X_PEAK_OUT <= x_c;
      if (gcac_abs(y_c) > gcac_abs(cmd[`GCAC_CB_PKCLR] ? 14'h0000 : Y_PEAK_OUT))
        Y_PEAK_OUT <= y_c;
      if (XY_RSS > (cmd[`GCAC_CB_PKCLR] ? 14'h0000 : XY_PEAK_OUT))
        XY_PEAK_OUT <= XY_RSS;
    end
  end
end

endmodule // gcac_core

// ===== test/gcac_chk_props.sv
`timescale 1ns/100ps
module gcac_chk #(
  parameter [22:0] FLUPD_CYC = 23'd20,
  parameter [22:0] CPCOPY_CYC = 23'd30
) (
  input wire CLK_SYS,
  input wire SRST,
  input wire CE,
  input wire CS_N,
  input wire DOUT_OE,
  input wire SAMPLE_VALID,
  input wire [13:0] XY_RSS,
  input wire CAL_VALID,
  input wire [13:0] XY_PEAK_OUT,
  input wire FLASH_BUSY,
  input wire SW_RESET_P,
  input wire DAC_LATCH_P,
  input wire CPTR_LOAD_P,
  input wire [15:0] CPTR_VALUE,
  input wire CFLASH_COPY_P,
  input wire STATUS_CLR_P
);
  reg [22:0] busy_cnt_r; // length of the current busy stretch
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (SRST);
  ////////////////////////////////////////////////////////////////
  // count busy cycles so the timer length can be judged at the fall
  always @(posedge CLK_SYS) begin
    if (SRST || !FLASH_BUSY) begin
      busy_cnt_r <= 23'h0;
    end else begin
      busy_cnt_r <= busy_cnt_r + 23'h1;
    end
  end
  ////////////////////////////////////////////////////////////////
  sw_pulse_a:
    assert property (SW_RESET_P |=> !SW_RESET_P) else $error("sw reset pulse too long");
  dac_pulse_a:
    assert property (DAC_LATCH_P |=> !DAC_LATCH_P) else $error("dac latch pulse too long");
  stclr_pulse_a:
    assert property (STATUS_CLR_P |=> !STATUS_CLR_P) else $error("status clear too long");
  cptr_value_a:
    assert property (CPTR_LOAD_P |-> CPTR_VALUE == 16'h0001) else $error("bad pointer value");
  cal_valid_a:
    assert property (SAMPLE_VALID && CE |=> CAL_VALID) else $error("no calibrated output");
  valid_cause_a:
    assert property (CAL_VALID |-> $past(SAMPLE_VALID)) else $error("stray calibrated valid");
  peak_hold_a:
    assert property (SAMPLE_VALID |=> XY_PEAK_OUT >= $past(XY_RSS)) else $error("peak lost");
  copy_idle_a:
    assert property (CFLASH_COPY_P |-> !FLASH_BUSY) else $error("copy while busy");
  copy_start_a:
    assert property (CFLASH_COPY_P |-> ##[1:2] FLASH_BUSY) else $error("copy timer idle");
  busy_len_a:
    assert property ($fell(FLASH_BUSY) |-> (busy_cnt_r + 23'h1 >= FLUPD_CYC
      && busy_cnt_r <= FLUPD_CYC + 23'h1) || (busy_cnt_r + 23'h1 >= CPCOPY_CYC
      && busy_cnt_r <= CPCOPY_CYC + 23'h1)) else $error("flash busy wrong length");
  oe_on_a:
    assert property ($fell(CS_N) |-> ##[3:6] DOUT_OE) else $error("data out not enabled");
  oe_off_a:
    assert property ($rose(CS_N) |-> ##[3:6] !DOUT_OE) else $error("data out not released");
  sw_seen_c: cover property (SW_RESET_P);
  copy_seen_c: cover property (CFLASH_COPY_P ##[1:2] FLASH_BUSY);
  cal_seen_c: cover property (SAMPLE_VALID ##1 CAL_VALID);
endmodule // gcac_chk
bind gcac_core gcac_chk #(.FLUPD_CYC(FLUPD_CYC), .CPCOPY_CYC(CPCOPY_CYC)) u_chk (
  .CLK_SYS(CLK_SYS), .SRST(SRST), .CE(CE), .CS_N(CS_N), .DOUT_OE(DOUT_OE),
  .SAMPLE_VALID(SAMPLE_VALID), .XY_RSS(XY_RSS),
  .CAL_VALID(CAL_VALID), .XY_PEAK_OUT(XY_PEAK_OUT), .FLASH_BUSY(FLASH_BUSY),
  .SW_RESET_P(SW_RESET_P), .DAC_LATCH_P(DAC_LATCH_P), .CPTR_LOAD_P(CPTR_LOAD_P),
  .CPTR_VALUE(CPTR_VALUE), .CFLASH_COPY_P(CFLASH_COPY_P), .STATUS_CLR_P(STATUS_CLR_P));

// ===== test/gcac_host.sv
`timescale 1ns/100ps
module gcac_host (
  input wire clk,
  input wire dout,
  output logic sclk,
  output logic cs_n,
  output logic din
);
  // serial clock idles high between frames (mode 3)
  initial begin
    sclk = 1'b1;
    cs_n = 1'b1;
    din = 1'b0;
  end
  // drive just after the rising edge, always by the same delay
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////
  // one 16-bit frame, msb first; six system clocks per half bit
  // leaves margin over the design's synchroniser lag
  task automatic xfer(input logic [15:0] w, output logic [15:0] r);
    cs_n = 1'b0;
    tick(6);
    for (int i = 15; i >= 0; i--) begin
      sclk = 1'b0;
      din = w[i];
      tick(6);
      r[i] = dout;
      sclk = 1'b1;
      tick(6);
    end
    cs_n = 1'b1;
    din = ~din; // released line must not keep the last bit
    tick(8);
  endtask
endmodule // gcac_host

// ===== test/global_command_and_calibration_tb_top.sv
`timescale 1ns/100ps
`include "gcac_consts.vh"
module global_command_and_calibration_tb_top;
  logic clk_sys, srst, sclk, cs_n, din, dout, valid, ffail, busy;
  logic [13:0] x_raw, y_raw, rss, x_cal, y_cal, x_pk, y_pk, xy_pk;
  logic [15:0] cptr, rdat;
  logic dac_p, stclr_p, sw_p, cbuf_p, cfclr_p, cptr_p, copy_p;
  int err_count, n_compared;
  int hits [0:10]; // pulses seen per command bit
  ////////////////////////////////////////////////////////////////
  // short flash timers keep the run brief but outlast one frame
  gcac_core #(.FLUPD_CYC(23'd600), .CPCOPY_CYC(23'd300)) u_dut (
    .CLK_SYS(clk_sys), .SRST(srst), .CE(1'b1), .SCLK(sclk), .CS_N(cs_n), .DIN(din),
    .X_RAW(x_raw), .Y_RAW(y_raw), .XY_RSS(rss), .SAMPLE_VALID(valid), .FLASH_FAIL(ffail),
    .DOUT(dout), .DOUT_OE(), .X_CAL_OUT(x_cal), .Y_CAL_OUT(y_cal), .CAL_VALID(),
    .X_PEAK_OUT(x_pk), .Y_PEAK_OUT(y_pk), .XY_PEAK_OUT(xy_pk), .FLASH_BUSY(busy),
    .SW_RESET_P(sw_p), .DAC_LATCH_P(dac_p), .CPTR_LOAD_P(cptr_p), .CPTR_VALUE(cptr),
    .CBUF_CLR_P(cbuf_p), .CFLASH_CLR_P(cfclr_p), .CFLASH_COPY_P(copy_p),
    .STATUS_CLR_P(stclr_p));
  gcac_host u_host (.clk(clk_sys), .dout(dout), .sclk(sclk), .cs_n(cs_n), .din(din));
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // outputs are unknown before the first reset edge, so count only after it
  always @(posedge clk_sys) begin
    if (!srst) begin
      hits[2] += dac_p;
      hits[4] += stclr_p;
      hits[6] += copy_p;
      hits[7] += sw_p;
      hits[8] += cbuf_p;
      hits[9] += cfclr_p;
      hits[10] += cptr_p;
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [15:0] r;
    u_host.xfer({1'b1, a, d}, r);
  endtask
  // a read answers in the following frame
  task automatic rd(input logic [6:0] a, output logic [15:0] r);
    logic [15:0] j;
    u_host.xfer({1'b0, a, 8'h00}, j);
    u_host.xfer({1'b0, a, 8'h00}, r);
  endtask
  task automatic cmd(input int b);
    wr(b > 7 ? `GCAC_ADR_CMDHI : `GCAC_ADR_CMDLO, 8'h01 << (b % 8));
  endtask
  task automatic smp(input logic [13:0] x, input logic [13:0] y, input logic [13:0] r);
    @(posedge clk_sys);
    #1;
    x_raw = x;
    y_raw = y;
    rss = r;
    valid = 1'b1;
    @(posedge clk_sys);
    #1;
    valid = 1'b0;
  endtask
  task automatic idle;
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 2000) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    chk("flash_busy", 16'h0000, {15'h0, busy});
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_cal;
    rd(`GCAC_ADR_XSCL, rdat);
    chk("x_gain_trim", {4'h0, `GCAC_RST_SCALE}, rdat);
    rd(`GCAC_ADR_YNULL, rdat);
    chk("y_offset_null", 16'h0000, rdat);
    wr(`GCAC_ADR_XSCL, 8'h00);
    wr(`GCAC_ADR_XSCL + 7'h1, 8'hf4);
    wr(`GCAC_ADR_XNULL, 8'h05);
    rd(`GCAC_ADR_XSCL, rdat);
    chk("x_gain_trim", 16'h0400, rdat);
    smp(14'd100, 14'h3fec, 14'd0);
    chk("x_cal", 16'd55, {2'b0, x_cal});
    chk("y_cal", 16'h3fec, {2'b0, y_cal});
    cmd(`GCAC_CB_FRST);
    rd(`GCAC_ADR_XSCL, rdat);
    chk("x_gain_trim", 16'h0800, rdat);
    rd(`GCAC_ADR_XNULL, rdat);
    chk("x_offset_null", 16'h0000, rdat);
    $display("test cal done");
  endtask
  task automatic t_peak;
    cmd(`GCAC_CB_PKCLR);
    smp(14'd50, 14'h3ff0, 14'd40);
    smp(14'h3fb0, 14'd8, 14'd90);
    smp(14'd30, 14'd0, 14'd20);
    chk("x_peak", 16'h3fb0, {2'b0, x_pk});
    chk("y_peak", 16'h3ff0, {2'b0, y_pk});
    chk("xy_peak", 16'd90, {2'b0, xy_pk});
    cmd(`GCAC_CB_PKCLR);
    chk("x_peak", {2'b0, `GCAC_PEAK_CLR}, {2'b0, x_pk});
    chk("y_peak", {2'b0, `GCAC_PEAK_CLR}, {2'b0, y_pk});
    chk("xy_peak", {2'b0, `GCAC_PEAK_CLR}, {2'b0, xy_pk});
    $display("test peak done");
  endtask
  task automatic t_anull;
    cmd(`GCAC_CB_ANULL);
    repeat (64) smp(14'd10, 14'h3ffc, 14'd0);
    rd(`GCAC_ADR_XNULL, rdat);
    chk("x_offset_null", 16'h0ff6, rdat);
    rd(`GCAC_ADR_YNULL, rdat);
    chk("y_offset_null", 16'h0004, rdat);
    cmd(`GCAC_CB_FRST);
    $display("test autonull done");
  endtask
  task automatic t_pulse;
    int h;
    int bits [0:6] = '{2, 4, 7, 8, 9, 10, 6};
    foreach (bits[i]) begin
      h = hits[bits[i]];
      cmd(bits[i]);
      chk("pulse count", 16'(h + 1), 16'(hits[bits[i]]));
    end
    chk("pointer value", `GCAC_CPTR_INIT, cptr);
    h = hits[8] + hits[9] + hits[10];
    wr(`GCAC_ADR_CMDHI, 8'hf8);
    chk("unused bits", 16'(h), 16'(hits[8] + hits[9] + hits[10]));
    idle();
    $display("test pulses done");
  endtask
  task automatic t_flash;
    int h;
    ffail = 1'b1;
    cmd(`GCAC_CB_FLUPD);
    chk("flash_busy", 16'h0001, {15'h0, busy});
    h = hits[6];
    cmd(`GCAC_CB_CPCOPY);
    chk("copy refused", 16'(h), 16'(hits[6]));
    idle();
    ffail = 1'b0;
    h = hits[9];
    cmd(`GCAC_CB_CFCLR);
    chk("clear refused", 16'(h), 16'(hits[9]));
    rd(`GCAC_ADR_STAT, rdat);
    chk("flash error", 16'h0001, {15'h0, rdat[`GCAC_ST_FLERR]});
    rd(`GCAC_ADR_STAT, rdat);
    chk("flash error", 16'h0000, {15'h0, rdat[`GCAC_ST_FLERR]});
    wr(`GCAC_ADR_XSCL, 8'h23);
    cmd(`GCAC_CB_FLUPD);
    idle();
    wr(`GCAC_ADR_XSCL, 8'h00);
    cmd(`GCAC_CB_SWRST);
    rd(`GCAC_ADR_XSCL, rdat);
    chk("x_gain_trim", 16'h0823, rdat);
    // a failed save again, this time cleared by the status command
    ffail = 1'b1;
    cmd(`GCAC_CB_FLUPD);
    idle();
    ffail = 1'b0;
    cmd(`GCAC_CB_STCLR);
    rd(`GCAC_ADR_STAT, rdat);
    chk("flash error", 16'h0000, {15'h0, rdat[`GCAC_ST_FLERR]});
    $display("test flash done");
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("compared %0d mismatched %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // about fifty frames of some 210 cycles each, nearly four times over for margin
  initial begin
    repeat (40000) @(posedge clk_sys);
    err_count++;
    $display("watchdog expired");
    complete_run();
  end
  initial begin
    srst = 1'b1;
    valid = 1'b0;
    ffail = 1'b0;
    x_raw = 14'h0;
    y_raw = 14'h0;
    rss = 14'h0;
    repeat (10) @(posedge clk_sys);
    #1;
    srst = 1'b0;
    // let the pin synchronisers settle before the first frame
    u_host.tick(4);
    t_cal();
    t_peak();
    t_anull();
    t_pulse();
    t_flash();
    complete_run();
  end
endmodule // global_command_and_calibration_tb_top
